// >>> sync_serial_regs.svh
`ifndef SYNC_SERIAL_REGS_SVH
`define SYNC_SERIAL_REGS_SVH

// ==========================================================
// Register offsets
`define ADDR_CONTROL_0 8'h00
`define ADDR_CONTROL_1 8'h04
`define ADDR_CONTROL_2 8'h08
`define ADDR_TX_BUFFER 8'h0C
`define ADDR_RX_BUFFER 8'h10
`define ADDR_STATUS 8'h14

// ==========================================================
// Field positions
`define BIT_POWER 7
`define BIT_TXE 6
`define BIT_DIR 4
`define BIT_CKP 4
`define BIT_DAP 3
`define CKS_MSB 2
`define CKS_LSB 0
`define CL_MSB 3
`define CL_LSB 0
`define BIT_BUSY 0
`define BIT_DONE 1

// ==========================================================
// Values
`define CKS_EXTERNAL 3'h7
`define BASE_WORD_BITS 5'h08
`define RESET_CTL 12'h000
`define RESET_DATA 16'h0000

// ==========================================================
// Timing
`define CLK_PERIOD_NS 5
`define HALF_PERIOD_BASE_NS 10
`define HALF_BASE_CYCLES \
  ((`HALF_PERIOD_BASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> sync_serial_pkg.sv
package sync_serial_pkg;

  typedef enum logic [3:0] {
    XFER_IDLE = 4'b0001,
    XFER_LEAD = 4'b0010,
    XFER_TRAIL = 4'b0100,
    XFER_TAIL = 4'b1000
  } xfer_state_t;

  typedef struct packed {
    logic power;
    logic txe;
    logic dir;
    logic ckp;
    logic dap;
    logic [2:0] cks;
    logic [3:0] cl;
  } serial_ctl_t;

  typedef struct packed {
    logic out;
    logic oe;
  } pin_drive_t;

endpackage

// >>> pin_sync.sv
`timescale 1ns/1ps

module pin_sync #(
  parameter logic INIT = 1'b0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);

  logic s1;
  logic s2;
  logic s3;

  // ==========================================================
  // Two-stage synchroniser, third stage only for edges
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  assign level = s2;
  assign rise = s2 & ~s3;
  assign fall = ~s2 & s3;

endmodule

// >>> shift_engine.sv
`timescale 1ns/1ps

module shift_engine #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic load,
  input wire logic [W-1:0] load_data,
  input wire logic present,
  input wire logic sample,
  input wire logic rx_bit,
  input wire logic dir,
  input wire logic [$clog2(W)-1:0] top_idx,
  output logic out_bit,
  output logic [W-1:0] rx_word
);

  logic [W-1:0] tx_sh;
  logic [W-1:0] next_rx;
  logic [W-1:0] src;

  initial begin
    if (W < 8 || W > 16) begin
      $error("shift_engine: W must be 8 to 16");
    end
  end

  assign src = load ? load_data : tx_sh;

  // ==========================================================
  // Receive shift: MSB first fills from bit 0, LSB first from top
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_rx
      logic from_up;
      if (i == W - 1) begin : g_top
        assign from_up = 1'b0;
      end else begin : g_mid
        assign from_up = (i < top_idx) ? rx_word[i+1] : 1'b0;
      end
      if (i == 0) begin : g_low
        assign next_rx[i] = dir ? ((top_idx == 0) ? rx_bit : from_up)
                                : rx_bit;
      end else begin : g_up
        assign next_rx[i] = dir ? ((i == top_idx) ? rx_bit : from_up)
                                : rx_word[i-1];
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tx_sh <= '0;
      rx_word <= '0;
    end else if (load) begin
      tx_sh <= load_data;
      rx_word <= '0;
    end else if (sample) begin
      tx_sh <= dir ? (tx_sh >> 1) : (tx_sh << 1);
      rx_word <= next_rx;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      out_bit <= 1'b0;
    end else if (present) begin
      out_bit <= dir ? src[0] : src[top_idx];
    end
  end

endmodule

// >>> clocked_serial_pin_control.sv
`timescale 1ns/1ps
`include "sync_serial_regs.svh"


module clocked_serial_pin_control #(
  parameter int MAX_BITS = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe,
  input wire logic serial_in_pin,
  output logic serial_out_pin
);

  localparam int IDX_W = $clog2(MAX_BITS);
  localparam logic [4:0] MAX_LEN = 5'(MAX_BITS);
  localparam logic [7:0] HALF_BASE = 8'(`HALF_BASE_CYCLES);

  initial begin
    if (MAX_BITS < 8 || MAX_BITS > 16) begin
      $error("MAX_BITS must be 8 to 16");
    end
  end

  sync_serial_pkg::serial_ctl_t ctl;
  sync_serial_pkg::xfer_state_t state;
  sync_serial_pkg::xfer_state_t next_state;
  sync_serial_pkg::pin_drive_t sck_drive;
  logic [MAX_BITS-1:0] tx_buf;
  logic [MAX_BITS-1:0] rx_word;
  logic [4:0] bit_cnt;
  logic [7:0] div_cnt;
  logic sck_level;
  logic done_flag;
  logic so_bit;
  logic sck_sync;
  logic sck_rise;
  logic sck_fall;
  logic si_sync;

  // ==========================================================
  // Register decode
  wire wr_ctl0 = reg_write && reg_addr == `ADDR_CONTROL_0;
  wire wr_ctl1 = reg_write && reg_addr == `ADDR_CONTROL_1;
  wire wr_ctl2 = reg_write && reg_addr == `ADDR_CONTROL_2;
  wire wr_tx = reg_write && reg_addr == `ADDR_TX_BUFFER;
  wire wr_status = reg_write && reg_addr == `ADDR_STATUS;
  wire busy = state != sync_serial_pkg::XFER_IDLE;
  wire start = wr_tx && ctl.power && !busy;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctl <= `RESET_CTL;
    end else begin
      if (wr_ctl0) begin
        ctl.power <= reg_wdata[`BIT_POWER];
        ctl.txe <= reg_wdata[`BIT_TXE];
        ctl.dir <= reg_wdata[`BIT_DIR];
      end
      if (wr_ctl1) begin
        ctl.ckp <= reg_wdata[`BIT_CKP];
        ctl.dap <= reg_wdata[`BIT_DAP];
        ctl.cks <= reg_wdata[`CKS_MSB:`CKS_LSB];
      end
      if (wr_ctl2) begin
        ctl.cl <= reg_wdata[`CL_MSB:`CL_LSB];
      end
    end
  end

  // Buffer writes during a transfer are refused
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tx_buf <= '0;
    end else if (wr_tx && !busy) begin
      tx_buf <= reg_wdata[MAX_BITS-1:0];
    end
  end

  // ==========================================================
  // Framing selection
  wire ext = ctl.cks == `CKS_EXTERNAL;
  wire idle_level = ~ctl.ckp;
  wire [4:0] len_raw = `BASE_WORD_BITS + {1'b0, ctl.cl};
  wire [4:0] word_len = (len_raw > MAX_LEN) ? MAX_LEN : len_raw;
  wire [IDX_W-1:0] top_idx = IDX_W'(word_len - 5'h01);
  wire last = bit_cnt == word_len - 5'h01;

  // ==========================================================
  // Clock sources
  pin_sync #(
    .INIT(1'b1)
  ) u_sck_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pin(serial_clock_pin_in),
    .level(sck_sync),
    .rise(sck_rise),
    .fall(sck_fall)
  );

  pin_sync #(
    .INIT(1'b0)
  ) u_si_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pin(serial_in_pin),
    .level(si_sync),
    .rise(),
    .fall()
  );

  wire [7:0] half_cycles = HALF_BASE << ctl.cks;
  wire int_tick = busy && !ext && div_cnt == half_cycles - 8'h01;

  always_ff @(posedge clk) begin
    if (!rst_b || !busy || int_tick) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sck_level <= 1'b1;
    end else if (!busy) begin
      sck_level <= idle_level;
    end else if (int_tick) begin
      sck_level <= ~sck_level;
    end
  end

  // Lead edge leaves the idle level, trail edge returns to it
  wire ext_lead = ctl.ckp ? sck_rise : sck_fall;
  wire ext_trail = ctl.ckp ? sck_fall : sck_rise;
  wire int_lead = int_tick && sck_level == idle_level;
  wire int_trail = int_tick && sck_level != idle_level;
  wire lead_evt = ext ? ext_lead : int_lead;
  wire trail_evt = ext ? ext_trail : int_trail;

  // ==========================================================
  // Transfer sequencer
  wire in_lead = state == sync_serial_pkg::XFER_LEAD && lead_evt;
  wire in_trail = state == sync_serial_pkg::XFER_TRAIL && trail_evt;
  wire in_tail = state == sync_serial_pkg::XFER_TAIL && trail_evt;
  wire present = (start && ctl.dap) || (in_lead && !ctl.dap)
                 || (in_trail && ctl.dap);
  wire sample = (in_lead && ctl.dap) || (in_trail && !ctl.dap);
  wire done_evt = (in_trail && !ctl.dap && last) || in_tail;

  always_comb begin
    next_state = state;
    case (state)
      sync_serial_pkg::XFER_IDLE: begin
        if (start) begin
          next_state = sync_serial_pkg::XFER_LEAD;
        end
      end
      sync_serial_pkg::XFER_LEAD: begin
        if (lead_evt) begin
          next_state = (ctl.dap && last) ? sync_serial_pkg::XFER_TAIL
                                         : sync_serial_pkg::XFER_TRAIL;
        end
      end
      sync_serial_pkg::XFER_TRAIL: begin
        if (trail_evt) begin
          next_state = (!ctl.dap && last) ? sync_serial_pkg::XFER_IDLE
                                          : sync_serial_pkg::XFER_LEAD;
        end
      end
      sync_serial_pkg::XFER_TAIL: begin
        if (trail_evt) begin
          next_state = sync_serial_pkg::XFER_IDLE;
        end
      end
      default: begin
        next_state = sync_serial_pkg::XFER_IDLE;
      end
    endcase
    if (!ctl.power) begin
      next_state = sync_serial_pkg::XFER_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= sync_serial_pkg::XFER_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b || start) begin
      bit_cnt <= 5'h00;
    end else if (sample) begin
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  // Completion wins over a software clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      done_flag <= 1'b0;
    end else if (done_evt) begin
      done_flag <= 1'b1;
    end else if (wr_status && reg_wdata[`BIT_DONE]) begin
      done_flag <= 1'b0;
    end
  end

  shift_engine #(
    .W(MAX_BITS)
  ) u_engine (
    .clk(clk),
    .rst_b(rst_b),
    .load(start),
    .load_data(reg_wdata[MAX_BITS-1:0]),
    .present(present),
    .sample(sample),
    .rx_bit(si_sync),
    .dir(ctl.dir),
    .top_idx(top_idx),
    .out_bit(so_bit),
    .rx_word(rx_word)
  );

  // ==========================================================
  // Pin drive
  wire first_bit = ctl.dir ? tx_buf[0] : tx_buf[top_idx];
  wire off_so = ctl.txe && ctl.dap && first_bit;
  wire on_so = ctl.txe && so_bit;

  assign sck_drive.oe = !ext;
  assign sck_drive.out = (busy && ctl.power) ? sck_level
                                             : idle_level;
  assign serial_clock_pin_out = sck_drive.out;
  assign serial_clock_pin_oe = sck_drive.oe;
  assign serial_out_pin = ctl.power ? on_so : off_so;

  // ==========================================================
  // Read-back
  wire [15:0] rd_ctl0 = {8'h00, ctl.power, ctl.txe, 1'b0, ctl.dir, 4'h0};
  wire [15:0] rd_ctl1 = {11'h000, ctl.ckp, ctl.dap, ctl.cks};
  wire [15:0] rd_ctl2 = {12'h000, ctl.cl};
  wire [15:0] rd_status = {14'h0000, done_flag, busy};
  wire [15:0] rd_sel =
    (reg_addr == `ADDR_CONTROL_0) ? rd_ctl0 :
    (reg_addr == `ADDR_CONTROL_1) ? rd_ctl1 :
    (reg_addr == `ADDR_CONTROL_2) ? rd_ctl2 :
    (reg_addr == `ADDR_TX_BUFFER) ? 16'(tx_buf) :
    (reg_addr == `ADDR_RX_BUFFER) ? 16'(rx_word) :
    (reg_addr == `ADDR_STATUS) ? rd_status : `RESET_DATA;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata <= `RESET_DATA;
    end else begin
      reg_rdata <= reg_read ? rd_sel : `RESET_DATA;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_off_ext_float;
    !ctl.power && ext |-> !serial_clock_pin_oe;
  endproperty
  a_off_ext_float: assert property (p_off_ext_float)
    else $error("clock pin driven while off with external clock");

  property p_off_int_level;
    !ctl.power && !ext |->
      serial_clock_pin_oe && serial_clock_pin_out == !ctl.ckp;
  endproperty
  a_off_int_level: assert property (p_off_int_level)
    else $error("wrong idle clock level while off");

  property p_cks_write;
    wr_ctl1 && !ctl.power |=> serial_clock_pin_oe ==
      ($past(reg_wdata[2:0]) != `CKS_EXTERNAL);
  endproperty
  a_cks_write: assert property (p_cks_write)
    else $error("clock pin enable did not follow source write");

  property p_off_txe_low;
    !ctl.power && !ctl.txe |-> !serial_out_pin;
  endproperty
  a_off_txe_low: assert property (p_off_txe_low)
    else $error("data pin not low while off and transmit disabled");

  property p_off_first_bit;
    !ctl.power && ctl.txe && ctl.dap && !ctl.dir |->
      serial_out_pin == tx_buf[top_idx];
  endproperty
  a_off_first_bit: assert property (p_off_first_bit)
    else $error("idle data pin not showing first bit");

  property p_txe_write;
    wr_ctl0 && !reg_wdata[`BIT_POWER] && !reg_wdata[`BIT_TXE]
      |=> !serial_out_pin;
  endproperty
  a_txe_write: assert property (p_txe_write)
    else $error("data pin not updated after control write");

  property p_ext_wait;
    state == sync_serial_pkg::XFER_LEAD && ext && !sck_rise && !sck_fall
      && ctl.power |=> state == sync_serial_pkg::XFER_LEAD;
  endproperty
  a_ext_wait: assert property (p_ext_wait)
    else $error("shift advanced without external clock edge");

  property p_type1_edges;
    ext && !ctl.ckp && !ctl.dap && sample |-> sck_rise;
  endproperty
  a_type1_edges: assert property (p_type1_edges)
    else $error("type 1 sample not on rising clock edge");

  property p_len8;
    ctl.cl == 4'h0 |-> word_len == 5'h08;
  endproperty
  a_len8: assert property (p_len8)
    else $error("length field 0000 not 8 bits");

  property p_msb_first;
    start && ctl.dap && !ctl.dir |=> so_bit == tx_buf[top_idx];
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("first bit is not most significant");

  property p_one_word;
    done_evt |-> bit_cnt == (ctl.dap ? word_len : word_len - 5'h01)
      ##1 !busy;
  endproperty
  a_one_word: assert property (p_one_word)
    else $error("transfer did not end after one word");

  property p_refuse_busy;
    busy && wr_tx |=> $stable(tx_buf);
  endproperty
  a_refuse_busy: assert property (p_refuse_busy)
    else $error("buffer changed during transfer");

  c_ext_type1: cover property (start && ext && !ctl.ckp && !ctl.dap);
  c_done: cover property (done_evt ##1 done_flag);
  c_dap_tail: cover property (in_tail);

endmodule

// >>> serial_master_model.sv
`timescale 1ns/1ps

// ==========================================================
// External master that supplies the serial clock, communication type 1
module serial_master_model (
  input wire logic start,
  input wire logic [15:0] send_word,
  input wire logic [4:0] nbits,
  input wire logic lsb_first,
  input wire logic data_in,
  output logic sck,
  output logic data_out,
  output logic [15:0] got_word,
  output logic active
);
  int idx;

  initial begin
    sck = 1'b1;
    data_out = 1'b0;
    got_word = 16'h0000;
    active = 1'b0;
    forever begin
      @(posedge start);
      active = 1'b1;
      got_word = 16'h0000;
      for (int i = 0; i < int'(nbits); i++) begin
        idx = lsb_first ? i : int'(nbits) - 1 - i;
        // Falling edge leads each bit; clock stands high between frames
        sck = 1'b0;
        #1;
        data_out = send_word[idx];
        #23;
        sck = 1'b1;
        got_word[idx] = data_in;
        #24;
      end
      // Released line shows the inverse, never a stale bit
      data_out = ~data_out;
      active = 1'b0;
    end
  end
endmodule

// >>> clocked_serial_pin_control_test.sv
`timescale 1ns/1ps
`include "sync_serial_regs.svh"

module clocked_serial_pin_control_test;
  logic clk;
  logic rst_b;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_write;
  logic reg_read;
  logic [15:0] reg_rdata;
  logic sck_out;
  logic sck_oe;
  logic sck_m;
  logic sck_wire;
  logic si;
  logic so;
  logic kick;
  logic lsb;
  logic [15:0] m_word;
  logic [15:0] m_got;
  logic m_act;
  logic [15:0] tx;
  logic [15:0] rd_val;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;

  assign sck_wire = sck_oe ? sck_out : sck_m;

  clocked_serial_pin_control #(.MAX_BITS(16)) dut (
    .clk(clk),
    .rst_b(rst_b),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .serial_clock_pin_in(sck_wire),
    .serial_clock_pin_out(sck_out),
    .serial_clock_pin_oe(sck_oe),
    .serial_in_pin(si),
    .serial_out_pin(so)
  );

  serial_master_model partner (
    .start(kick),
    .send_word(m_word),
    .nbits(5'h08),
    .lsb_first(lsb),
    .data_in(so),
    .sck(sck_m),
    .data_out(si),
    .got_word(m_got),
    .active(m_act)
  );

  // ==========================================================
  // Helpers
  function automatic logic [15:0] exp_ck(logic ckp, logic [2:0] cks);
    return (cks == 3'h7) ? 16'h0000 : {14'h0000, 1'b1, ~ckp};
  endfunction

  function automatic logic exp_so(logic txe, logic dap, logic dir,
                                  logic [15:0] t);
    return (txe & dap) ? (dir ? t[0] : t[7]) : 1'b0;
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask

  task automatic results();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      results();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    rst_b = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
    kick = 1'b0;
    lsb = 1'b0;
    m_word = 16'h0000;
    void'($urandom(32'h53CB));
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    check({14'h0000, sck_oe, sck_out}, 16'h0003);
    check({15'h0000, so}, 16'h0000);
    wr(8'h20, 16'hFFFF);
    rd(8'h20);
    check(rd_val, 16'h0000);
    // Idle clock level over every polarity and source
    for (int k = 0; k < 16; k++) begin
      wr(`ADDR_CONTROL_1, {11'h000, k[3], 1'b0, k[2:0]});
      check({14'h0000, sck_oe, sck_oe & sck_out},
            exp_ck(k[3], k[2:0]));
    end
    // Idle data level over transmit, direction and phase
    tx = {8'h00, 8'($urandom())};
    tx[7] = ~tx[0];
    wr(`ADDR_TX_BUFFER, tx);
    for (int k = 0; k < 8; k++) begin
      wr(`ADDR_CONTROL_1, {11'h000, 1'b0, k[0], 3'h7});
      wr(`ADDR_CONTROL_0, {8'h00, 1'b0, k[2], 1'b0, k[1], 4'h0});
      check({15'h0000, so},
            {15'h0000, exp_so(k[2], k[0], k[1], tx)});
    end
    // Slave transfers on the external clock
    wr(`ADDR_CONTROL_2, 16'h0000);
    for (int n = 0; n < 6; n++) begin
      lsb = (n >= 4);
      tx = (n == 0) ? 16'h00FF : {8'h00, 8'($urandom())};
      m_word = (n == 0) ? 16'h0000 : {8'h00, 8'($urandom())};
      wr(`ADDR_CONTROL_1, 16'h0007);
      wr(`ADDR_CONTROL_0, {8'h00, 2'b11, 1'b0, lsb, 4'h0});
      wr(`ADDR_TX_BUFFER, tx);
      rd(`ADDR_STATUS);
      check(rd_val & 16'h0001, 16'h0001);
      check({15'h0000, sck_oe}, 16'h0000);
      if (n == 1) begin
        wr(`ADDR_TX_BUFFER, ~tx);
      end
      @(posedge clk);
      kick <= 1'b1;
      @(posedge clk);
      kick <= 1'b0;
      do @(posedge clk); while (m_act === 1'b1);
      for (int w = 0; w < 10; w++) begin
        rd(`ADDR_STATUS);
        if (rd_val[0] === 1'b0) begin
          break;
        end
      end
      check(rd_val & 16'h0003, 16'h0002);
      check(m_got, tx);
      rd(`ADDR_RX_BUFFER);
      check(rd_val, m_word);
      wr(`ADDR_STATUS, 16'h0002);
    end
    // Master mode on the internal clock, phase 1, both polarities
    for (int p = 0; p < 2; p++) begin
      wr(`ADDR_CONTROL_1, {11'h000, p[0], 1'b1, 3'h0});
      wr(`ADDR_TX_BUFFER, 16'h00A5);
      check({15'h0000, sck_oe}, 16'h0001);
      repeat (60) @(posedge clk);
      rd(`ADDR_STATUS);
      check(rd_val & 16'h0003, 16'h0002);
      rd(`ADDR_RX_BUFFER);
      check(rd_val, si ? 16'h00FF : 16'h0000);
      wr(`ADDR_STATUS, 16'h0002);
    end
    results();
  end
endmodule
